// ---- verilog/aspc_core.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - After reset status reads error and full flags 0, done and empty 1.
// - Frame: one low start bit, optional parity, one or two high stops.
// - Source code 110 uses the external timer tick; bit is sixteen ticks.
// - Idle receiver samples the pin each tick and starts on a low level.
// - Each received bit is voted from samples at ticks 7, 8 and 9.
// - Enabled buffer write after a status read clears empty flag; byte is then shifted out.
// - At transmit start empty flag sets and transmit interrupt pulses.
// - Transmit pin stays high until first byte written, and after a disable once the current frame ends.
// - Completed frame loads data byte, sets full flag, pulses interrupt.
// - Frame arriving while buffer full sets overrun, byte discarded.
// - No reception starts while overrun flag is set.
// - Receive disable takes effect only when the current frame ends.
// - Parity error when computed parity differs from received parity.
// - Framing error when a sampled stop bit is 0.
// - Receive flags clear on buffer read following a status read.
// - Overrun set after the status read survives the buffer read.
// - Done flag sets when a byte is sent and buffer empty; clears on start.
// - Transmit stop length 0 gives one stop bit, 1 gives two.
// - Parity add enables the parity bit; sense picks odd or even.
// - Source codes pick clock divide 13..416, external timer, or 96.
// - Receive stop length 0 expects one stop bit, 1 expects two.
// - Noise filter rejects pulses under 31, 63 or 127 clocks; 00 none.
module aspc_core #(
    parameter int ADDR_W = 12
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    input  wire logic              serial_in_pin,
    output logic                   serial_out_pin,
    input  wire logic              external_baud_timer_tick,
    output logic                   transmit_irq,
    output logic                   receive_irq
);
    if (ADDR_W < aspc_pkg::ADDR_MIN_W) begin : g_bad_addr
        $error("aspc_core: ADDR_W too small for the register map");
    end

    // Parity of a byte for the chosen sense
    function automatic logic par_of(input logic [7:0] d, input logic ev);
        par_of = ev ? (^d) : ~(^d);
    endfunction : par_of

    // Divider figure for a baud source code
    function automatic logic [8:0] div_of(input logic [2:0] sel);
        case (sel)
            3'h0:    div_of = aspc_pkg::DIV_13;
            3'h1:    div_of = aspc_pkg::DIV_26;
            3'h2:    div_of = aspc_pkg::DIV_52;
            3'h3:    div_of = aspc_pkg::DIV_104;
            3'h4:    div_of = aspc_pkg::DIV_208;
            3'h5:    div_of = aspc_pkg::DIV_416;
            default: div_of = aspc_pkg::DIV_96;
        endcase
    endfunction : div_of

    logic [7:0]          ctrl1_ff;
    logic [2:0]          ctrl2_ff;
    logic [7:0]          rx_buf_ff;
    logic [7:0]          tx_buf_ff;
    logic [7:0]          rdata_ff;
    logic                parity_error_flag_ff, framing_error_flag_ff, overrun_error_flag_ff, rx_buffer_full_flag_ff, transmit_done_flag_ff, tx_buffer_empty_flag_ff;
    logic                armed_ff;
    logic [3:0]          snap_ff;
    logic                tx_irq_ff, rx_irq_ff;
    logic [8:0]          div_cnt_ff;
    logic [6:0]          nf_cnt_ff;
    logic                nf_lvl_ff;
    aspc_pkg::aspc_state_t tx_st_ff, rx_st_ff;
    logic [3:0]          tx_tick_ff, rx_tick_ff;
    logic [2:0]          tx_bits_ff, rx_bits_ff;
    logic [7:0]          tx_sh_ff, rx_sh_ff;
    logic                tx_par_ff, rx_par_ff, out_ff;
    logic [1:0]          rx_smp_ff;
    logic                rx_fe_ff;

    logic                transmit_enable, receive_enable, tx_stop_length, even_par, pe, rx_stop_length;
    logic [2:0]          baud_source_select;
    logic [1:0]          nf_sel;
    logic [6:0]          nf_len;
    logic                xfer_tick, rx_in, vote;
    logic                wr_data, rd_data, rd_stat, wr_c1, wr_c2;
    logic                tx_start, tx_adv, tx_end, rx_end, rx_vote;
    logic [7:0]          status;

    // Field decode
    assign transmit_enable      = ctrl1_ff[aspc_pkg::BIT_TXE];
    assign receive_enable      = ctrl1_ff[aspc_pkg::BIT_RXE];
    assign tx_stop_length     = ctrl1_ff[aspc_pkg::BIT_TX_STOP_LENGTH];
    assign even_par = ctrl1_ff[aspc_pkg::BIT_EVEN];
    assign pe       = ctrl1_ff[aspc_pkg::BIT_PE];
    assign baud_source_select      = ctrl1_ff[aspc_pkg::BRG_HI:aspc_pkg::BRG_LO];
    assign nf_sel   = ctrl2_ff[aspc_pkg::NF_HI:aspc_pkg::NF_LO];
    assign rx_stop_length   = ctrl2_ff[aspc_pkg::BIT_RX_STOP_LENGTH];

    // Bus strobes; status and control one share an address
    assign rd_stat = reg_rd && (reg_addr == ADDR_W'(aspc_pkg::ADDR_STAT_CTRL1));
    assign wr_c1   = reg_wr && (reg_addr == ADDR_W'(aspc_pkg::ADDR_STAT_CTRL1));
    assign wr_c2   = reg_wr && (reg_addr == ADDR_W'(aspc_pkg::ADDR_CTRL2));
    assign rd_data = reg_rd && (reg_addr == ADDR_W'(aspc_pkg::ADDR_DATA));
    assign wr_data = reg_wr && (reg_addr == ADDR_W'(aspc_pkg::ADDR_DATA));

    assign status = {parity_error_flag_ff, framing_error_flag_ff, overrun_error_flag_ff, rx_buffer_full_flag_ff, transmit_done_flag_ff, tx_buffer_empty_flag_ff,
                     2'b00};

    // Control registers, write only
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl1_ff <= aspc_pkg::CTRL1_RESET;
            ctrl2_ff <= aspc_pkg::CTRL2_RESET;
        end else begin
            if (wr_c1) begin
                ctrl1_ff <= reg_wdata;
            end
            if (wr_c2) begin
                ctrl2_ff <= reg_wdata[2:0];
            end
        end
    end

    // Read data, one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_ff <= aspc_pkg::BYTE_RESET;
        end else if (rd_stat) begin
            rdata_ff <= status;
        end else if (rd_data) begin
            rdata_ff <= rx_buf_ff;
        end else begin
            rdata_ff <= aspc_pkg::BYTE_RESET;
        end
    end
    assign reg_rdata = rdata_ff;

    // Transfer clock: system clock divider or external timer tick
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            div_cnt_ff <= 9'h000;
        end else if (xfer_tick || baud_source_select == aspc_pkg::BRG_EXT) begin
            div_cnt_ff <= 9'h000;
        end else begin
            div_cnt_ff <= div_cnt_ff + 9'h001;
        end
    end
    assign xfer_tick = (baud_source_select == aspc_pkg::BRG_EXT) ? external_baud_timer_tick
                     : (div_cnt_ff == div_of(baud_source_select) - 9'h001);

    // Noise filter: a new level must hold for the selected length
    always_comb begin
        case (nf_sel)
            2'h1:    nf_len = aspc_pkg::NF_LEN_1;
            2'h2:    nf_len = aspc_pkg::NF_LEN_2;
            default: nf_len = aspc_pkg::NF_LEN_3;
        endcase
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            nf_cnt_ff <= 7'h00;
            nf_lvl_ff <= 1'b1;
        end else if (serial_in_pin == nf_lvl_ff) begin
            nf_cnt_ff <= 7'h00;
        end else if (nf_cnt_ff >= nf_len - 7'h01) begin
            nf_lvl_ff <= serial_in_pin;
            nf_cnt_ff <= 7'h00;
        end else begin
            nf_cnt_ff <= nf_cnt_ff + 7'h01;
        end
    end
    assign rx_in = (nf_sel == 2'h0) ? serial_in_pin : nf_lvl_ff;

    // Status flags and buffers; a set always beats a clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            parity_error_flag_ff   <= 1'b0;
            framing_error_flag_ff   <= 1'b0;
            overrun_error_flag_ff   <= 1'b0;
            rx_buffer_full_flag_ff   <= 1'b0;
            transmit_done_flag_ff   <= 1'b1;
            tx_buffer_empty_flag_ff   <= 1'b1;
            armed_ff  <= 1'b0;
            snap_ff   <= 4'h0;
            rx_buf_ff <= aspc_pkg::BYTE_RESET;
            tx_buf_ff <= aspc_pkg::BYTE_RESET;
            tx_irq_ff <= 1'b0;
            rx_irq_ff <= 1'b0;
        end else begin
            tx_irq_ff <= tx_start;
            rx_irq_ff <= rx_end && !rx_buffer_full_flag_ff;
            if (rd_stat) begin
                armed_ff <= 1'b1;
                snap_ff  <= status[7:4];
            end else if (rd_data || wr_data) begin
                armed_ff <= 1'b0;
            end
            // Buffer read after status read clears what status showed
            if (rd_data && armed_ff) begin
                parity_error_flag_ff <= parity_error_flag_ff && !snap_ff[3];
                framing_error_flag_ff <= framing_error_flag_ff && !snap_ff[2];
                overrun_error_flag_ff <= overrun_error_flag_ff && !snap_ff[1];
                rx_buffer_full_flag_ff <= rx_buffer_full_flag_ff && !snap_ff[0];
            end
            if (wr_data && armed_ff && transmit_enable) begin
                tx_buf_ff <= reg_wdata;
                tx_buffer_empty_flag_ff   <= 1'b0;
            end
            if (tx_start) begin
                tx_buffer_empty_flag_ff <= 1'b1;
                transmit_done_flag_ff <= 1'b0;
            end
            if (tx_end && tx_buffer_empty_flag_ff && !(wr_data && armed_ff && transmit_enable)) begin
                transmit_done_flag_ff <= 1'b1;
            end
            if (rx_end) begin
                if (rx_buffer_full_flag_ff) begin
                    overrun_error_flag_ff <= 1'b1;
                end else begin
                    rx_buf_ff <= rx_sh_ff;
                    rx_buffer_full_flag_ff   <= 1'b1;
                    parity_error_flag_ff   <= pe && (rx_par_ff != par_of(rx_sh_ff,
                                                       even_par));
                    framing_error_flag_ff   <= rx_fe_ff || !vote;
                end
            end
        end
    end
    assign transmit_irq = tx_irq_ff;
    assign receive_irq  = rx_irq_ff;

    // Transmit sequencing strobes
    assign tx_start = (tx_st_ff == aspc_pkg::ASPC_IDLE) && transmit_enable && !tx_buffer_empty_flag_ff;
    assign tx_adv   = xfer_tick && (tx_tick_ff == aspc_pkg::TICK_LAST);
    assign tx_end   = tx_adv && ((tx_st_ff == aspc_pkg::ASPC_STOP2) ||
                      (tx_st_ff == aspc_pkg::ASPC_STOP1 && !tx_stop_length));

    // Transmitter frame sequencer
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tx_st_ff   <= aspc_pkg::ASPC_IDLE;
            tx_tick_ff <= 4'h0;
            tx_bits_ff <= 3'h0;
            tx_sh_ff   <= aspc_pkg::BYTE_RESET;
            tx_par_ff  <= 1'b0;
            out_ff     <= 1'b1;
        end else if (tx_st_ff == aspc_pkg::ASPC_IDLE) begin
            out_ff <= 1'b1;
            if (tx_start) begin
                tx_st_ff   <= aspc_pkg::ASPC_START;
                tx_sh_ff   <= tx_buf_ff;
                tx_par_ff  <= par_of(tx_buf_ff, even_par);
                tx_tick_ff <= 4'h0;
                tx_bits_ff <= 3'h0;
                out_ff     <= 1'b0;
            end
        end else begin
            if (xfer_tick) begin
                tx_tick_ff <= tx_tick_ff + 4'h1;
            end
            if (tx_adv) begin
                case (tx_st_ff)
                    aspc_pkg::ASPC_START: begin
                        tx_st_ff <= aspc_pkg::ASPC_DATA;
                        out_ff   <= tx_sh_ff[0];
                    end
                    aspc_pkg::ASPC_DATA: begin
                        tx_sh_ff   <= {1'b0, tx_sh_ff[7:1]};
                        tx_bits_ff <= tx_bits_ff + 3'h1;
                        if (tx_bits_ff != aspc_pkg::LAST_DATA) begin
                            out_ff <= tx_sh_ff[1];
                        end else if (pe) begin
                            tx_st_ff <= aspc_pkg::ASPC_PARITY;
                            out_ff   <= tx_par_ff;
                        end else begin
                            tx_st_ff <= aspc_pkg::ASPC_STOP1;
                            out_ff   <= 1'b1;
                        end
                    end
                    aspc_pkg::ASPC_PARITY: begin
                        tx_st_ff <= aspc_pkg::ASPC_STOP1;
                        out_ff   <= 1'b1;
                    end
                    aspc_pkg::ASPC_STOP1: begin
                        tx_st_ff <= tx_stop_length ? aspc_pkg::ASPC_STOP2
                                         : aspc_pkg::ASPC_IDLE;
                    end
                    default: begin
                        tx_st_ff <= aspc_pkg::ASPC_IDLE;
                        out_ff   <= 1'b1;
                    end
                endcase
            end
        end
    end
    assign serial_out_pin = out_ff;

    // Receive vote and frame completion
    assign vote    = (rx_smp_ff[0] & rx_smp_ff[1]) | (rx_smp_ff[0] & rx_in) |
                     (rx_smp_ff[1] & rx_in);
    assign rx_vote = xfer_tick && (rx_tick_ff == aspc_pkg::TICK_S2);
    assign rx_end  = rx_vote && ((rx_st_ff == aspc_pkg::ASPC_STOP2) ||
                     (rx_st_ff == aspc_pkg::ASPC_STOP1 && !rx_stop_length));

    // Receiver frame sequencer
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rx_st_ff   <= aspc_pkg::ASPC_IDLE;
            rx_tick_ff <= 4'h0;
            rx_bits_ff <= 3'h0;
            rx_sh_ff   <= aspc_pkg::BYTE_RESET;
            rx_par_ff  <= 1'b0;
            rx_smp_ff  <= 2'b11;
            rx_fe_ff   <= 1'b0;
        end else if (rx_st_ff == aspc_pkg::ASPC_IDLE) begin
            // Enable and overrun gate only a new frame
            if (xfer_tick && receive_enable && !overrun_error_flag_ff && !rx_in) begin
                rx_st_ff   <= aspc_pkg::ASPC_START;
                rx_tick_ff <= 4'h1;
                rx_bits_ff <= 3'h0;
                rx_fe_ff   <= 1'b0;
            end
        end else if (xfer_tick) begin
            rx_tick_ff <= rx_tick_ff + 4'h1;
            if (rx_tick_ff == aspc_pkg::TICK_S0) begin
                rx_smp_ff[0] <= rx_in;
            end
            if (rx_tick_ff == aspc_pkg::TICK_S1) begin
                rx_smp_ff[1] <= rx_in;
            end
            if (rx_end) begin
                rx_st_ff <= aspc_pkg::ASPC_IDLE;
            end else if (rx_vote) begin
                case (rx_st_ff)
                    aspc_pkg::ASPC_START: begin
                        if (vote) begin
                            rx_st_ff <= aspc_pkg::ASPC_IDLE;
                        end
                    end
                    aspc_pkg::ASPC_DATA: begin
                        rx_sh_ff <= {vote, rx_sh_ff[7:1]};
                    end
                    aspc_pkg::ASPC_PARITY: begin
                        rx_par_ff <= vote;
                    end
                    default: begin
                        rx_fe_ff <= !vote;
                    end
                endcase
            end else if (rx_tick_ff == aspc_pkg::TICK_LAST) begin
                case (rx_st_ff)
                    aspc_pkg::ASPC_START: begin
                        rx_st_ff <= aspc_pkg::ASPC_DATA;
                    end
                    aspc_pkg::ASPC_DATA: begin
                        rx_bits_ff <= rx_bits_ff + 3'h1;
                        if (rx_bits_ff == aspc_pkg::LAST_DATA) begin
                            rx_st_ff <= pe ? aspc_pkg::ASPC_PARITY
                                           : aspc_pkg::ASPC_STOP1;
                        end
                    end
                    aspc_pkg::ASPC_PARITY: begin
                        rx_st_ff <= aspc_pkg::ASPC_STOP1;
                    end
                    default: begin
                        rx_st_ff <= aspc_pkg::ASPC_STOP2;
                    end
                endcase
            end
        end
    end

    // Checks
    AST_RESET_STATUS: assert property (@(posedge mclk)
        $fell(rst) |-> status == 8'h0C)
        else $error("status wrong after reset");
    AST_IDLE_HIGH: assert property (@(posedge mclk) disable iff (rst)
        (tx_st_ff == aspc_pkg::ASPC_IDLE) |-> serial_out_pin)
        else $error("transmit pin low while idle");
    AST_START_LOW: assert property (@(posedge mclk) disable iff (rst)
        tx_start |=> !serial_out_pin && tx_buffer_empty_flag_ff && transmit_irq)
        else $error("transmit start without low start bit");
    AST_WRITE_EMPTY: assert property (@(posedge mclk)
        disable iff (rst)
        wr_data && armed_ff && transmit_enable && !tx_start |=> !tx_buffer_empty_flag_ff)
        else $error("buffer write did not clear empty flag");
    AST_NO_ARM: assert property (@(posedge mclk) disable iff (rst)
        wr_data && !armed_ff && tx_buffer_empty_flag_ff && !tx_start |=> tx_buffer_empty_flag_ff)
        else $error("unarmed write started transmission");
    AST_OVERRUN: assert property (@(posedge mclk) disable iff (rst)
        rx_end && rx_buffer_full_flag_ff |=> overrun_error_flag_ff && rx_buf_ff == $past(rx_buf_ff))
        else $error("overrun not flagged or buffer altered");
    AST_LOAD: assert property (@(posedge mclk) disable iff (rst)
        rx_end && !rx_buffer_full_flag_ff |=> rx_buffer_full_flag_ff && receive_irq)
        else $error("receive load failed");
    AST_BLOCK: assert property (@(posedge mclk) disable iff (rst)
        overrun_error_flag_ff && rx_st_ff == aspc_pkg::ASPC_IDLE
        |=> rx_st_ff == aspc_pkg::ASPC_IDLE)
        else $error("reception started during overrun");
    AST_RDBACK: assert property (@(posedge mclk) disable iff (rst)
        rd_stat |=> reg_rdata == $past(status))
        else $error("status readback mismatch");
    // A later change of source legally ends the divide by 13 period
    AST_DIV: assert property (@(posedge mclk) disable iff (rst)
        baud_source_select == 3'h0 && xfer_tick && !wr_c1
        |-> ##13 (xfer_tick || baud_source_select != 3'h0))
        else $error("divide by 13 period wrong");

    COV_TX: cover property (@(posedge mclk) disable iff (rst) tx_end);
    COV_RX: cover property (@(posedge mclk) disable iff (rst)
        rx_end && !rx_buffer_full_flag_ff);
    COV_OVR: cover property (@(posedge mclk) disable iff (rst)
        rx_end && rx_buffer_full_flag_ff);
endmodule : aspc_core

// ---- pkg/aspc_pkg.sv ----
package aspc_pkg;
    // Register map
    localparam logic [11:0] ADDR_STAT_CTRL1 = 12'hF95;
    localparam logic [11:0] ADDR_CTRL2      = 12'hF96;
    localparam logic [11:0] ADDR_DATA       = 12'hF97;
    localparam int          ADDR_MIN_W      = 12;

    // Status register bit positions
    localparam int BIT_PARITY_ERROR_FLAG = 7;
    localparam int BIT_FRAMING_ERROR_FLAG = 6;
    localparam int BIT_OVERRUN_ERROR_FLAG = 5;
    localparam int BIT_RX_BUFFER_FULL_FLAG = 4;
    localparam int BIT_TRANSMIT_DONE_FLAG = 3;
    localparam int BIT_TX_BUFFER_EMPTY_FLAG = 2;

    // Control one fields
    localparam int BIT_TXE  = 7;
    localparam int BIT_RXE  = 6;
    localparam int BIT_TX_STOP_LENGTH = 5;
    localparam int BIT_EVEN = 4;
    localparam int BIT_PE   = 3;
    localparam int BRG_HI   = 2;
    localparam int BRG_LO   = 0;

    // Control two fields
    localparam int NF_HI      = 2;
    localparam int NF_LO      = 1;
    localparam int BIT_RX_STOP_LENGTH = 0;

    // Reset values
    localparam logic [7:0] CTRL1_RESET  = 8'h00;
    localparam logic [2:0] CTRL2_RESET  = 3'h0;
    localparam logic [7:0] BYTE_RESET   = 8'h00;

    // Baud source codes and divider figures in system clocks
    localparam logic [2:0] BRG_EXT = 3'h6;
    localparam logic [8:0] DIV_13  = 9'h00D;
    localparam logic [8:0] DIV_26  = 9'h01A;
    localparam logic [8:0] DIV_52  = 9'h034;
    localparam logic [8:0] DIV_104 = 9'h068;
    localparam logic [8:0] DIV_208 = 9'h0D0;
    localparam logic [8:0] DIV_416 = 9'h1A0;
    localparam logic [8:0] DIV_96  = 9'h060;

    // Sample ticks within a sixteen tick bit
    localparam logic [3:0] TICK_S0   = 4'h7;
    localparam logic [3:0] TICK_S1   = 4'h8;
    localparam logic [3:0] TICK_S2   = 4'h9;
    localparam logic [3:0] TICK_LAST = 4'hF;
    localparam logic [2:0] LAST_DATA = 3'h7;

    // Noise reject lengths in system clocks
    localparam logic [6:0] NF_LEN_1 = 7'h1F;
    localparam logic [6:0] NF_LEN_2 = 7'h3F;
    localparam logic [6:0] NF_LEN_3 = 7'h7F;

    // Frame sequencer states, Gray along the usual path
    typedef enum logic [2:0] {
        ASPC_IDLE   = 3'h0,
        ASPC_START  = 3'h1,
        ASPC_DATA   = 3'h3,
        ASPC_PARITY = 3'h2,
        ASPC_STOP1  = 3'h6,
        ASPC_STOP2  = 3'h7
    } aspc_state_t;
endpackage : aspc_pkg

// ---- bench/aspc_remote.sv ----
`timescale 1ns/1ps
// Far-side serial device: sends frames to the port and samples its output
module aspc_remote #(
    parameter int BIT_NS = 5200
) (
    output logic      remote_data,
    input  wire logic local_data
);
    // Line rests high between frames
    initial begin
        remote_data = 1'b1;
    end

    // Start low, eight bits LSB first, optional parity, then stop
    task automatic send_frame(input logic [7:0] d, input logic use_par,
                              input logic par_bit, input logic stop_lvl);
        int i;
        #7;
        remote_data = 1'b0;
        #(BIT_NS);
        for (i = 0; i < 8; i++) begin
            remote_data = d[i];
            #(BIT_NS);
        end
        if (use_par) begin
            remote_data = par_bit;
            #(BIT_NS);
        end
        remote_data = stop_lvl;
        #(BIT_NS);
        remote_data = 1'b1;
        #(BIT_NS);
    endtask : send_frame

    // Samples twelve bit centres from the falling edge of the start bit
    task automatic take_frame(output logic [11:0] fr);
        int i;
        @(negedge local_data);
        #(BIT_NS / 2);
        for (i = 0; i < 12; i++) begin
            fr[i] = local_data;
            #(BIT_NS);
        end
    endtask : take_frame
endmodule : aspc_remote

// ---- bench/tb_async_serial_port_core.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module tb_async_serial_port_core;
    localparam logic [11:0] ST = aspc_pkg::ADDR_STAT_CTRL1;
    localparam logic [11:0] DT = aspc_pkg::ADDR_DATA;
    logic        mclk;
    logic        rst;
    logic [11:0] reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        line_in;
    logic        line_out;
    logic        ext_tick;
    logic        tx_irq;
    logic        rx_irq;
    logic [11:0] fr;
    logic [7:0]  d;
    int          k;
    int          fail_count = 0;
    int          cmp_count = 0;
    int          cycle_count = 0;
    int          tx_irqs = 0;
    int          rx_irqs = 0;
    logic [7:0]  rx_d [3] = '{8'h3C, 8'h81, 8'h7E};
    logic [7:0]  rx_st [3] = '{8'h1C, 8'h9C, 8'h5C};
    logic [2:0]  rx_pf = 3'b010;
    logic [2:0]  rx_sl = 3'b011;

    aspc_core dut_u (
        .mclk                     (mclk),
        .rst                      (rst),
        .reg_addr                 (reg_addr),
        .reg_wdata                (reg_wdata),
        .reg_wr                   (reg_wr),
        .reg_rd                   (reg_rd),
        .reg_rdata                (reg_rdata),
        .serial_in_pin            (line_in),
        .serial_out_pin           (line_out),
        .external_baud_timer_tick (ext_tick),
        .transmit_irq             (tx_irq),
        .receive_irq              (rx_irq)
    );

    aspc_remote #(.BIT_NS(16 * 13 * 25)) remote_u (
        .remote_data (line_in),
        .local_data  (line_out)
    );

    // 40 MHz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // Cuts a hang short, ticks the external timer, counts interrupts
    always @(posedge mclk) begin
        cycle_count <= cycle_count + 1;
        ext_tick <= (cycle_count % 13 == 12);
        tx_irqs <= tx_irqs + int'(tx_irq);
        rx_irqs <= rx_irqs + int'(rx_irq);
        if (cycle_count == 60000) begin
            fail_count++;
            stop_test();
        end
    end

    // One-cycle write strobe, then a gap cycle
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask : wr

    // One-cycle read strobe; data checked in the following cycle
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
        @(posedge mclk);
    endtask : rd

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    // Main sequence
    initial begin
        rst = 1'b1;
        reg_addr = 12'h000;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(ST, 8'h0C);
        rd(DT, 8'h00);
        rd(12'hF90, 8'h00);
        `CHK(line_out, 1'b1)
        wr(ST, 8'hF8);
        wr(DT, 8'h00);
        repeat (300) @(posedge mclk);
        `CHK(line_out, 1'b1)
        rd(ST, 8'h0C);
        $display("reset and refusal test done");
        // Even then odd parity, two stop bits
        for (k = 0; k < 2; k++) begin
            d = (k == 1) ? 8'h5B : 8'hA6;
            wr(ST, (k == 1) ? 8'hE8 : 8'hF8);
            fork
                remote_u.take_frame(fr);
                begin
                    rd(ST, 8'h0C);
                    wr(DT, d);
                    repeat (4) @(posedge mclk);
                    rd(ST, 8'h04);
                end
            join
            `CHK(fr, {2'b11, (^d) ^ k[0], d, 1'b0})
            @(posedge mclk);
            rd(ST, 8'h0C);
        end
        $display("transmit test done");
        // Good frame, parity error, framing error
        wr(ST, 8'hF8);
        for (k = 0; k < 3; k++) begin
            d = rx_d[k];
            remote_u.send_frame(d, 1'b1, (^d) ^ rx_pf[k], rx_sl[k]);
            @(posedge mclk);
            rd(ST, rx_st[k]);
            rd(DT, d);
            rd(ST, 8'h0C);
        end
        $display("receive test done");
        remote_u.send_frame(8'h11, 1'b1, 1'b0, 1'b1);
        @(posedge mclk);
        rd(ST, 8'h1C);
        remote_u.send_frame(8'h22, 1'b1, 1'b0, 1'b1);
        @(posedge mclk);
        rd(DT, 8'h11);
        rd(ST, 8'h2C);
        remote_u.send_frame(8'h33, 1'b1, 1'b0, 1'b1);
        @(posedge mclk);
        rd(DT, 8'h11);
        rd(ST, 8'h0C);
        $display("overrun test done");
        // External tick, no parity, one stop out, two stops in, filter on
        wr(ST, 8'h00);
        wr(ST, 8'hC6);
        wr(12'hF96, 8'h03);
        fork
            remote_u.take_frame(fr);
            begin
                rd(ST, 8'h0C);
                wr(DT, 8'hC5);
            end
        join
        `CHK(fr, {3'b111, 8'hC5, 1'b0})
        fork
            remote_u.send_frame(8'h96, 1'b0, 1'b0, 1'b1);
            begin
                repeat (600) @(posedge mclk);
                wr(ST, 8'h86);
            end
        join
        @(posedge mclk);
        rd(ST, 8'h1C);
        rd(DT, 8'h96);
        `CHK(tx_irqs, 3)
        `CHK(rx_irqs, 5)
        $display("external tick test done");
        stop_test();
    end
endmodule : tb_async_serial_port_core
